/* pli_link_init.sv */
`timescale 1ns/1ns
module pli_link_init
  import pli_pkg::*;
#(
  parameter int ACT_CYCLES = ACTIVATE_MIN_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic link_osc,
  input wire logic link_power_status,
  input wire logic iso_mode,
  input wire logic ports_active,
  input wire logic link_request_line,
  input wire logic [CTL_W-1:0] control_lines_in,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic link_clock_out,
  output logic link_clock_oe,
  output logic [CTL_W-1:0] control_lines_out,
  output logic control_lines_oe,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  output logic link_request_taken,
  output logic interface_disabled,
  output logic low_power_state,
  output logic init_complete
);
  localparam logic [CNT_W-1:0] ACT_LAST = CNT_W'(ACT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the mclk domain
  logic lps_s;
  logic ports_s;
  logic done_s;
  logic done;

  pli_sync #(.W(3)) u_sync_m (
    .clk(mclk),
    .rstn(rstn),
    .d({link_power_status, ports_active, done}),
    .q({lps_s, ports_s, done_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interface state in the mclk domain
  pli_if_state_t state;
  pli_if_state_t next_state;
  logic [CNT_W-1:0] off_cnt;
  logic [CNT_W-1:0] next_off_cnt;
  logic [CNT_W-1:0] rest_cnt;
  logic [CNT_W-1:0] next_rest_cnt;
  logic [CNT_W-1:0] act_cnt;
  logic [CNT_W-1:0] next_act_cnt;
  logic clk_run;
  logic next_clk_run;
  logic link_up;
  logic next_link_up;
  logic low_power;
  logic next_low_power;
  logic rest_done;

  assign rest_done = (rest_cnt == RESTORE_DONE);

  // Status-low time, restore time and restart wait, then the state step
  always_comb begin
    next_state = state;
    next_off_cnt = off_cnt;
    next_rest_cnt = rest_cnt;
    next_act_cnt = act_cnt;
    next_clk_run = clk_run;
    next_link_up = link_up;
    if (lps_s) begin
      next_off_cnt = '0;
    end else if (off_cnt != DISABLE_SAT) begin
      next_off_cnt = off_cnt + 1'b1;
    end
    // Restore interval runs from the moment the interface went down
    if (state == IF_RESET || state == IF_DISABLED) begin
      if (!rest_done) begin
        next_rest_cnt = rest_cnt + 1'b1; // R18
      end
    end else begin
      next_rest_cnt = '0;
    end
    unique case (state)
      IF_UP: begin
        if (!lps_s && off_cnt >= RESET_LAST) begin
          next_state = IF_RESET;
          next_link_up = 1'b0;
        end
      end
      IF_RESET: begin
        if (!lps_s && off_cnt >= DISABLE_LAST) begin
          next_state = IF_DISABLED; // R19
          next_clk_run = 1'b0;
        end else if (lps_s && rest_done) begin
          next_state = IF_UP; // R3
          next_link_up = 1'b1;
        end
      end
      IF_DISABLED: begin
        if (lps_s && rest_done) begin
          if (low_power) begin
            next_state = IF_ACTIVATE; // R4
            next_act_cnt = '0;
          end else begin
            next_state = IF_UP; // R5
            next_clk_run = 1'b1;
            next_link_up = 1'b1;
          end
        end
      end
      IF_ACTIVATE: begin
        if (!lps_s) begin
          next_state = IF_DISABLED;
        end else if (act_cnt == ACT_LAST) begin
          next_state = IF_UP; // R4
          next_clk_run = 1'b1;
          next_link_up = 1'b1;
        end else begin
          next_act_cnt = act_cnt + 1'b1;
        end
      end
    endcase
    // Low power while disabled and idle on the cable side, and through the low-power restart wait
    next_low_power = (state == IF_DISABLED && !ports_s) || state == IF_ACTIVATE; // R21
  end

  // Hardware reset leaves the interface disabled with the clock stopped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= IF_DISABLED; // R20
      off_cnt <= '0;
      rest_cnt <= '0;
      act_cnt <= '0;
      clk_run <= 1'b0;
      link_up <= 1'b0;
      low_power <= 1'b0;
      interface_disabled <= 1'b1;
      low_power_state <= 1'b0;
      init_complete <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      off_cnt <= next_off_cnt;
      rest_cnt <= next_rest_cnt;
      act_cnt <= next_act_cnt;
      clk_run <= next_clk_run;
      link_up <= next_link_up;
      low_power <= next_low_power;
      interface_disabled <= (next_state == IF_DISABLED);
      low_power_state <= next_low_power;
      init_complete <= done_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the link domain
  logic run_l;
  logic up_l;
  logic ce_l;
  logic iso_l;
  logic link_request_line_l;

  // Status reaches the link side only through two flops
  pli_sync #(.W(5)) u_sync_l (
    .clk(link_osc),
    .rstn(rstn),
    .d({clk_run, link_up, ce, iso_mode, link_request_line}),
    .q({run_l, up_l, ce_l, iso_l, link_request_line_l}) // R23
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link-side sequencer; one link clock cycle is two oscillator cycles
  pli_link_state_t lst;
  pli_link_state_t next_lst;
  logic [CYC_W-1:0] cyc;
  logic [CYC_W-1:0] next_cyc;
  logic next_ph;
  logic next_ck_oe;
  logic [CTL_W-1:0] next_ctl;
  logic next_ctl_oe;
  logic [DATA_W-1:0] next_dat;
  logic next_dat_oe;
  logic next_done;
  logic next_taken;

  // A cycle starts where the clock output is about to rise
  always_comb begin
    next_lst = lst;
    next_cyc = cyc;
    next_ph = ~link_clock_out; // R6
    next_ck_oe = 1'b1;
    unique case (lst)
      LK_STOP: begin
        next_ph = 1'b0;
        next_ck_oe = iso_l; // R17
        if (run_l) begin
          next_lst = LK_HALF;
          next_ck_oe = 1'b1;
        end
      end
      LK_HALF: begin
        next_ph = 1'b1; // R7
        next_lst = LK_WAIT;
      end
      LK_WAIT: begin
        if (up_l && !link_clock_out) begin
          next_lst = LK_INIT; // R23
          next_cyc = FIRST_CYC;
        end
      end
      LK_INIT: begin
        if (!link_clock_out) begin
          if (cyc == INIT_CYCLES) begin
            next_lst = LK_RECV; // R13
            next_cyc = FIRST_CYC;
          end else begin
            next_cyc = cyc + 1'b1;
          end
        end
      end
      LK_RECV: begin
        if (!link_clock_out && cyc == RECV_CYCLES) begin
          next_lst = LK_IDLE; // R15
        end else if (!link_clock_out) begin
          next_cyc = cyc + 1'b1;
        end
      end
      LK_IDLE: begin
        next_lst = LK_IDLE;
      end
    endcase
    // Status loss resets the sequence; a stopped clock overrides all
    if (lst != LK_STOP && !run_l) begin
      next_lst = LK_STOP;
      next_ph = 1'b0;
      next_ck_oe = iso_l; // R17
    end else if (!up_l && (lst == LK_INIT || lst == LK_RECV || lst == LK_IDLE)) begin
      next_lst = LK_WAIT; // R3
    end
    // Line drive follows the state being entered
    next_ctl = CTL_IDLE; // R22
    next_dat = DATA_ZERO;
    next_done = 1'b0;
    unique case (next_lst)
      LK_INIT: begin
        next_ctl_oe = pli_drive_en(iso_l, next_cyc); // R1 R8 R10
      end
      LK_RECV: begin
        next_ctl = CTL_RECEIVE; // R13
        next_dat = DATA_ON;
        next_ctl_oe = pli_drive_en(iso_l, next_cyc); // R14
      end
      LK_IDLE: begin
        next_ctl_oe = 1'b1; // R15
        next_done = 1'b1;
      end
      default: begin
        // Reset and disabled: low when non-differentiated, else floating
        next_ctl_oe = iso_l;
      end
    endcase
    next_dat_oe = next_ctl_oe;
    // Requests count only once idle has been put out
    next_taken = link_request_line_l && done; // R16
  end

  // Link-side registers; frozen while the enable is low
  always_ff @(posedge link_osc or negedge rstn) begin
    if (!rstn) begin
      lst <= LK_STOP;
      cyc <= '0;
      link_clock_out <= 1'b0;
      link_clock_oe <= 1'b0;
      control_lines_out <= CTL_IDLE;
      control_lines_oe <= 1'b0;
      data_lines_out <= DATA_ZERO;
      data_lines_oe <= 1'b0;
      done <= 1'b0;
      link_request_taken <= 1'b0;
    end else if (ce_l) begin
      lst <= next_lst;
      cyc <= next_cyc;
      link_clock_out <= next_ph;
      link_clock_oe <= next_ck_oe;
      control_lines_out <= next_ctl;
      control_lines_oe <= next_ctl_oe;
      data_lines_out <= next_dat;
      data_lines_oe <= next_dat_oe;
      done <= next_done;
      link_request_taken <= next_taken;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks in the mclk domain
  chk_fast_restart: assert property (@(posedge mclk) disable iff (!rstn) // R5
    ce && state == IF_DISABLED && lps_s && rest_done && !low_power |=> clk_run && link_up)
    else $error("clock not restored at once from full-power disable");

  chk_slow_restart: assert property (@(posedge mclk) disable iff (!rstn) // R4
    ce && state == IF_ACTIVATE && next_state == IF_UP |-> act_cnt == ACT_LAST && !clk_run)
    else $error("low-power restart left its wait early");

  chk_reset_entry: assert property (@(posedge mclk) disable iff (!rstn) // R19
    ce && state == IF_UP && !lps_s && off_cnt == RESET_LAST |=> state == IF_RESET && clk_run)
    else $error("short status loss did not reset with the clock kept running");

  chk_disable_entry: assert property (@(posedge mclk) disable iff (!rstn) // R19
    ce && state == IF_RESET && !lps_s && off_cnt == DISABLE_LAST |=> state == IF_DISABLED
      && !clk_run)
    else $error("interface not disabled after long status loss");

  chk_restore_wait: assert property (@(posedge mclk) disable iff (!rstn) // R18
    ce && (state == IF_RESET || state == IF_DISABLED) && !rest_done |=> state != IF_UP)
    else $error("interface came up before the restore interval");

  chk_low_power: assert property (@(posedge mclk) disable iff (!rstn) // R21
    ce && state == IF_DISABLED && !ports_s |=> low_power_state)
    else $error("low-power state missing while disabled and idle");

  ////////////////////////////////////////////////////////////////////////////
  // Checks in the link domain
  sequence s_init_end;
    ce_l && run_l && up_l && lst == LK_INIT && cyc == INIT_CYCLES && !link_clock_out;
  endsequence

  sequence s_recv_start;
    lst == LK_RECV && control_lines_out == CTL_RECEIVE && data_lines_out == DATA_ON
      && control_lines_oe && data_lines_oe;
  endsequence

  chk_recv_code: assert property (@(posedge link_osc) disable iff (!rstn) // R13
    s_init_end |=> s_recv_start)
    else $error("receive code not sent on the eighth cycle");

  chk_recv_float: assert property (@(posedge link_osc) disable iff (!rstn) // R14
    lst == LK_RECV && cyc == RECV_CYCLES && !iso_l && $stable(iso_l) |-> !control_lines_oe)
    else $error("differentiated receive still driven after first cycle");

  chk_nondiff_low: assert property (@(posedge link_osc) disable iff (!rstn) // R10
    lst == LK_INIT && iso_l && $stable(iso_l) |-> control_lines_oe && data_lines_oe
      && control_lines_out == CTL_IDLE && data_lines_out == DATA_ZERO)
    else $error("non-differentiated lines not held low");

  chk_diff_first: assert property (@(posedge link_osc) disable iff (!rstn) // R8
    lst == LK_INIT && !iso_l && $stable(iso_l) |-> control_lines_oe == (cyc == FIRST_CYC))
    else $error("differentiated first-cycle drive wrong");

  chk_idle_done: assert property (@(posedge link_osc) disable iff (!rstn) // R15
    lst == LK_IDLE |-> done && control_lines_oe && control_lines_out == CTL_IDLE
      && data_lines_out == DATA_ZERO)
    else $error("idle not signalled at end of initialization");

  chk_req_gate: assert property (@(posedge link_osc) disable iff (!rstn) // R16
    ce_l && !done |=> !link_request_taken)
    else $error("request taken before initialization completed");

  chk_half_low: assert property (@(posedge link_osc) disable iff (!rstn) // R7
    ce_l && lst == LK_HALF && run_l |-> !link_clock_out && link_clock_oe ##1 link_clock_out)
    else $error("clock start did not hold low for half a period");

  chk_stop_level: assert property (@(posedge link_osc) disable iff (!rstn) // R17
    lst == LK_STOP && $past(lst) == LK_STOP && $stable(iso_l) |-> !link_clock_out
      && link_clock_oe == iso_l)
    else $error("stopped clock not low or floating by mode");

endmodule

/* pli_pkg.sv */
// Function
// R1: Mode pin low selects differentiated sequence
// R2: Link controller waits restore interval first
// R3: Same sequence after reset or disable
// R4: Low-power restart waits 5.3 to 7.3 ms
// R5: Otherwise clock restarts within 60 ns
// R6: Link clock is 50% square wave
// R7: Differentiated start holds clock low half-period
// R8: Differentiated: lines low for first cycle
// R9: Controller drives low within first six cycles
// R10: Non-differentiated: lines low for seven cycles
// R11: Controller drives low once, then floats
// R12: Controller holds request low during initialization; the model does so only when non-differentiated
// R13: Eighth cycle: receive code, data all ones
// R14: Differentiated receive floats after first cycle
// R15: Idle code and zero data end initialization
// R16: Requests ignored until idle is signalled
// R17: Disabled clock: low or floating by mode
// R18: Restore interval is 15 microseconds minimum
// R19: Disable after 26.03 to 26.11 us low
// R20: Hardware reset leaves interface disabled
// R21: Disabled with no active port: low power
// R22: Control codes: idle 00, receive 10
// R23: Synchronize status; count from first clock edge
package pli_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Line widths and codes
  localparam int DATA_W = 8;
  localparam int CTL_W = 2;
  localparam logic [CTL_W-1:0] CTL_IDLE = 2'h0;
  localparam logic [CTL_W-1:0] CTL_RECEIVE = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ON = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Times in their own units, and derived cycle counts at mclk
  localparam real MCLK_PERIOD_NS = 40.0;
  localparam real RESET_DETECT_US = 2.6;
  localparam real DISABLE_MIN_US = 26.03;
  localparam real DISABLE_MAX_US = 26.11;
  localparam real RESTORE_MIN_US = 15.0;
  localparam real ACTIVATE_MIN_MS = 5.3;
  localparam real ACTIVATE_MAX_MS = 7.3;
  localparam real FAST_RESTORE_NS = 60.0;
  localparam int RESET_DETECT_CYC = int'($ceil(RESET_DETECT_US * 1000.0 / MCLK_PERIOD_NS));
  localparam int DISABLE_MIN_CYC = int'($ceil(DISABLE_MIN_US * 1000.0 / MCLK_PERIOD_NS));
  localparam int DISABLE_MAX_CYC = int'($floor(DISABLE_MAX_US * 1000.0 / MCLK_PERIOD_NS));
  localparam int RESTORE_CYC = int'($ceil(RESTORE_MIN_US * 1000.0 / MCLK_PERIOD_NS));
  localparam int ACTIVATE_MIN_CYC = int'($ceil(ACTIVATE_MIN_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int ACTIVATE_MAX_CYC = int'($floor(ACTIVATE_MAX_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int FAST_RESTORE_RAW = int'($floor(FAST_RESTORE_NS / MCLK_PERIOD_NS));
  localparam int FAST_RESTORE_CYC = (FAST_RESTORE_RAW < 1) ? 1 : FAST_RESTORE_RAW;

  // Counter width covers the longest restart wait
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_DETECT_CYC - 1);
  localparam logic [CNT_W-1:0] DISABLE_LAST = CNT_W'(DISABLE_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] DISABLE_SAT = CNT_W'(DISABLE_MIN_CYC);
  localparam logic [CNT_W-1:0] RESTORE_DONE = CNT_W'(RESTORE_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Link-clock cycle counts of the initialization sequence
  localparam int CYC_W = 4;
  localparam logic [CYC_W-1:0] FIRST_CYC = 4'h1;
  localparam logic [CYC_W-1:0] INIT_CYCLES = 4'h7;
  localparam logic [CYC_W-1:0] RECV_CYCLES = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // States
  typedef enum logic [1:0] {IF_DISABLED, IF_RESET, IF_ACTIVATE, IF_UP} pli_if_state_t;
  typedef enum logic [2:0] {LK_STOP, LK_HALF, LK_WAIT, LK_INIT, LK_RECV, LK_IDLE}
    pli_link_state_t;

  // Lines are driven in every non-differentiated cycle, else only the first one
  function automatic logic pli_drive_en(input logic non_diff, input logic [CYC_W-1:0] cyc);
    pli_drive_en = non_diff | (cyc == FIRST_CYC);
  endfunction

endpackage

/* pli_sync.sv */
`timescale 1ns/1ns
module pli_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // Two flops per bit; only the second stage is visible outside
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule

/* pli_lc_model.sv */
`timescale 1ns/1ns
module pli_lc_model (
  input wire logic link_clock_out,
  input wire logic link_power_status,
  input wire logic iso_mode,
  input wire logic init_complete,
  input wire logic req_want,
  output logic lc_oe,
  output logic lc_req_oe,
  output logic lc_req
);
  int cyc;

  // Counts link clock cycles since status was raised; saturates to stay small
  always @(posedge link_clock_out or negedge link_power_status) begin
    if (!link_power_status) begin
      cyc <= 0;
    end else if (cyc < 15) begin
      cyc <= cyc + 1;
    end
  end

  // Shared lines driven low in the first cycle only, then released
  assign lc_oe = link_power_status && (cyc == 1);
  // Request held low through init when non-differentiated; otherwise driven from the first cycle on while status is up
  assign lc_req_oe = iso_mode || (link_power_status && cyc >= 1);
  assign lc_req = (!link_power_status || cyc == 1 || (iso_mode && !init_complete)) ? 1'b0 :
    req_want;
endmodule

/* phy_link_interface_init_tb.sv */
`timescale 1ns/1ns
module phy_link_interface_init_tb;
  import pli_pkg::*;
  localparam int ACT = 20;
  logic mclk, rstn, ce, link_osc, link_power_status, iso_mode, ports_active;
  logic link_request_line, req_want, req_fl, lc_oe, lc_req_oe, lc_req;
  logic [CTL_W-1:0] control_lines_in, control_lines_out;
  logic [DATA_W-1:0] data_lines_in, data_lines_out;
  logic link_clock_out, link_clock_oe, control_lines_oe, data_lines_oe;
  logic link_request_taken, interface_disabled, low_power_state, init_complete;
  int n_fail, cmp_count, lat;
  time t_lps;

  ////////////////////////////////////////////////////////////////////////////
  // Clocks: link oscillator is unrelated in phase to mclk
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    link_osc = 1'b0;
    #7;
    forever #32 link_osc = ~link_osc;
  end

  // Released wires show a changing pattern so stale values never pass
  always @(negedge link_osc) req_fl <= ~req_fl;
  assign control_lines_in = control_lines_oe ? control_lines_out : (lc_oe ? 2'h0 : {2{req_fl}});
  assign data_lines_in = data_lines_oe ? data_lines_out : (lc_oe ? 8'h00 : {8{req_fl}});
  assign link_request_line = lc_req_oe ? lc_req : req_fl;

  pli_link_init #(.ACT_CYCLES(ACT)) u_pli_link_init (.mclk(mclk), .rstn(rstn), .ce(ce),
    .link_osc(link_osc), .link_power_status(link_power_status), .iso_mode(iso_mode),
    .ports_active(ports_active), .link_request_line(link_request_line),
    .control_lines_in(control_lines_in), .data_lines_in(data_lines_in),
    .link_clock_out(link_clock_out), .link_clock_oe(link_clock_oe),
    .control_lines_out(control_lines_out), .control_lines_oe(control_lines_oe),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .link_request_taken(link_request_taken), .interface_disabled(interface_disabled),
    .low_power_state(low_power_state), .init_complete(init_complete));

  pli_lc_model u_pli_lc_model (.link_clock_out(link_clock_out),
    .link_power_status(link_power_status), .iso_mode(iso_mode),
    .init_complete(init_complete), .req_want(req_want), .lc_oe(lc_oe),
    .lc_req_oe(lc_req_oe), .lc_req(lc_req));

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of one init cycle: {enable, control, data}
  function automatic logic [10:0] exp_line(logic nd, int k);
    if (k <= 7) return {nd | (k == 1), CTL_IDLE, DATA_ZERO};
    if (k <= 9) return {nd | (k == 8), CTL_RECEIVE, DATA_ON};
    return {1'b1, CTL_IDLE, DATA_ZERO};
  endfunction

  task automatic chk_flag(string name, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // A released line is judged on its enable only
  task automatic chk_line(int k, logic [10:0] exp, logic [10:0] got);
    logic [10:0] g;
    g = exp[10] ? got : {got[10], exp[9:0]};
    cmp_count++;
    if (g !== exp) begin
      n_fail++;
      $display("[FAIL] line cycle %0d expected %h seen %h", k, exp, got);
    end
  endtask

  // Samples each link cycle in its high half, then lines up on receive
  task automatic run_init(logic nd, logic req_on);
    logic [10:0] q[$];
    int r;
    logic prev_oe;
    logic prev_ck;
    logic oe;
    r = -1;
    lat = -1;
    prev_oe = link_clock_oe;
    prev_ck = link_clock_out;
    for (int i = 0; i < 800; i++) begin
      if (r >= 0 && q.size() >= r + 4) break;
      @(negedge link_osc);
      if (!prev_oe && link_clock_oe) chk_flag("clock starts low", 1'b0, link_clock_out);
      if (lat >= 0) chk_flag("clock toggles", ~prev_ck, link_clock_out);
      prev_oe = link_clock_oe;
      prev_ck = link_clock_out;
      if (link_clock_out === 1'b1) begin
        if (lat < 0) lat = int'(($time - t_lps) / 40);
        // Control and data share one enable; a split between them shows up as unknown
        oe = (control_lines_oe === data_lines_oe) ? control_lines_oe : 1'bx;
        q.push_back({oe, control_lines_out, data_lines_out});
        if (r < 0 && control_lines_oe && control_lines_out === CTL_RECEIVE) r = q.size() - 1;
        if (r < 0 && req_on) chk_flag("request held off", 1'b0, link_request_taken);
      end
    end
    chk_flag("receive after seven cycles", 1'b1, r >= 7);
    for (int k = 1; k <= 11 && r >= 7; k++) chk_line(k, exp_line(nd, k), q[r - 8 + k]);
  endtask

  // Long drop, then a full restore interval before anyone reasserts
  task automatic drop_long();
    link_power_status = 1'b0;
    repeat (600) @(negedge mclk);
    chk_flag("not disabled early", 1'b0, interface_disabled);
    repeat (100) @(negedge mclk);
    chk_flag("disabled after long drop", 1'b1, interface_disabled);
    chk_flag("low power state", ~ports_active, low_power_state);
    repeat (RESTORE_CYC) @(negedge mclk);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h961816ab));
    n_fail = 0;
    cmp_count = 0;
    req_fl = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    link_power_status = 1'b0;
    iso_mode = 1'b1;
    ports_active = 1'b1;
    req_want = 1'b0;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    t_lps = $time;
    chk_flag("disabled after reset", 1'b1, interface_disabled);
    chk_flag("no done after reset", 1'b0, init_complete);
    // Early reassertion must wait out the restore interval
    repeat (50) @(negedge mclk);
    link_power_status = 1'b1;
    run_init(1'b1, 1'b0);
    chk_flag("restore interval kept", 1'b1, lat >= RESTORE_CYC);
    repeat (8) @(negedge mclk);
    chk_flag("done after idle", 1'b1, init_complete);
    chk_flag("full power", 1'b0, low_power_state);
    // Short random drop: reset only, rerun differentiated with request up
    link_power_status = 1'b0;
    iso_mode = 1'b0;
    repeat (RESET_DETECT_CYC + RESTORE_CYC + 10 + ($urandom % 100)) @(negedge mclk);
    chk_flag("short drop keeps link", 1'b0, interface_disabled);
    chk_flag("clock runs in reset", 1'b1, link_clock_oe);
    req_want = 1'b1;
    link_power_status = 1'b1;
    t_lps = $time;
    run_init(1'b0, 1'b1);
    repeat (6) @(negedge link_osc);
    chk_flag("request taken", 1'b1, link_request_taken);
    req_want = 1'b0;
    // Disable at full power, fast restart non-differentiated
    drop_long();
    chk_flag("diff clock floats", 1'b0, link_clock_oe);
    iso_mode = 1'b1;
    repeat (10) @(negedge mclk);
    chk_flag("nondiff clock driven", 1'b1, link_clock_oe);
    chk_flag("nondiff clock low", 1'b0, link_clock_out);
    link_power_status = 1'b1;
    t_lps = $time;
    run_init(1'b1, 1'b0);
    chk_flag("fast restart", 1'b1, lat <= 16);
    // Disable with no port active, slow restart differentiated
    ports_active = 1'b0;
    iso_mode = 1'b0;
    drop_long();
    link_power_status = 1'b1;
    t_lps = $time;
    run_init(1'b0, 1'b0);
    chk_flag("slow restart window", 1'b1, lat >= ACT && lat <= ACT + 16);
    repeat (8) @(negedge mclk);
    chk_flag("done after slow restart", 1'b1, init_complete);
    // Hardware reset in mid-run, then the whole start-up again from disabled
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    t_lps = $time;
    chk_flag("disabled by hardware reset", 1'b1, interface_disabled);
    chk_flag("done cleared by reset", 1'b0, init_complete);
    run_init(1'b0, 1'b0);
    chk_flag("restore and wait after reset", 1'b1, lat >= RESTORE_CYC + ACT);
    // Enable low freezes the status timers, so a long drop must do nothing yet
    ce = 1'b0;
    link_power_status = 1'b0;
    repeat (800) @(negedge mclk);
    chk_flag("frozen while enable low", 1'b0, interface_disabled);
    ce = 1'b1;
    repeat (700) @(negedge mclk);
    chk_flag("disabled after enable returns", 1'b1, interface_disabled);
    complete_run();
  end

  // Watchdog: the whole sequence needs about 5200 mclk cycles
  initial begin
    #(40 * 20000);
    n_fail++;
    $display("[FAIL] watchdog expected finish seen timeout");
    complete_run();
  end
endmodule
